/* File: evcap_pkg.sv */
package evcap_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL0_OFS   = 8'h00;
    localparam logic [7:0] CTRL2_OFS   = 8'h04;
    localparam logic [7:0] FLAG_OFS    = 8'h08;
    localparam logic [7:0] FLGCLR_OFS  = 8'h0c;
    localparam logic [7:0] INTEN_OFS   = 8'h10;
    localparam logic [7:0] SYNCSEL_OFS = 8'h14;
    localparam logic [7:0] PHASE_OFS   = 8'h18;
    localparam logic [7:0] COUNT_OFS   = 8'h1c;
    localparam logic [7:0] CAP0_OFS    = 8'h20;
    localparam logic [7:0] PERIOD_OFS  = 8'h30;
    localparam logic [7:0] CMP_OFS     = 8'h34;
    localparam logic [7:0] UNLOCK_OFS  = 8'h38;
    // ----------------------------------------------------------------
    // capture_control_two fields
    // ----------------------------------------------------------------
    localparam int CT_CONT    = 0;
    localparam int CT_STOPLO  = 1;
    localparam int CT_REARM   = 3;
    localparam int CT_RUN     = 4;
    localparam int CT_SYNCEN  = 5;
    localparam int CT_SWSYNC  = 6;
    localparam int CT_PWMMODE = 7;
    localparam int CT_CLEAR   = 8;
    localparam int CT_SEQLO   = 9;
    localparam int CT_POL0    = 16;
    localparam int CT_DELTA0  = 20;
    localparam int CT_DMALO   = 24;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL2_RST  = 32'h0000_0006;
    localparam logic [31:0] PERIOD_RST = 32'hffff_ffff;
    localparam logic [6:0]  INSEL_RST  = 7'h00;
    localparam logic [1:0]  SYNCSEL_RST = 2'h0;
    localparam logic [31:0] ERR_DATA   = 32'h0000_0000;
    typedef enum logic [1:0] {
        SYNC_SW, SYNC_PWM, SYNC_CAP, SYNC_XBAR
    } sync_src_t;
endpackage

/* File: edge_pick.sv */
`timescale 1ns/100ps
module edge_pick (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic last;

    // ----------------------------------------------------------------
    // Two-stage synchroniser, edge detect after the second stage only
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= din;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise = sync & ~last;
    assign fall = ~sync & last;
endmodule // edge_pick

/* File: event_capture_timestamp.sv */
// Functional notes
// - Four 32-bit capture registers latch the counter on sequenced events.
// - Each of the four events picks rising or falling edge.
// - Interrupt can be raised on any chosen capture event.
// - Single-shot captures up to a stop count, then halts until rearm.
// - Continuous mode loads the four registers as a circular buffer.
// - Absolute or delta capture; delta resets counter on the event.
// - Without capture mode, drive single-channel PWM on auxiliary output.
// - Writing 1 to clear bit resets filter, sequence counter, pending flags.
// - Status field reports sequence counter: next register to load.
// - DMA trigger source selectable among the four capture events.
// - Seven-bit selector chooses capture input from 128 signals.
// - Critical writes need unlock; legacy select removes the protection.
// - The unit owns its own sync source select register.
// - Sync from software or external PWM, capture unit or crossbar.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module event_capture_timestamp
    import evcap_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [127:0] captureInputs,
    input  wire logic        pwmSync,
    input  wire logic        capSync,
    input  wire logic        xbarSync,
    input  wire logic        legacyProtectionSelect,
    output logic             captureIrq,
    output logic             captureDmaTrigger,
    output logic             auxPwmOutput
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [6:0]  captureInputSelect;
    logic [31:0] captureControlTwo;
    logic [3:0]  flags;
    logic [3:0]  intEnable;
    logic [1:0]  syncSourceSelect;
    logic [31:0] phase;
    logic [31:0] counter;
    logic [31:0] capReg [4];
    logic [31:0] period;
    logic [31:0] compare;
    logic        unlocked;
    logic [1:0]  seq;
    logic        armed;
    logic        pwmOut;
    logic [127:0] inMeta;
    logic [127:0] inSync;
    logic        selLast;
    logic        selNow;
    logic        evRise;
    logic        evFall;
    logic        evHit;
    logic        capEvent;
    logic        extSync;
    logic        syncEvent;
    logic        wrEn;
    logic        critWrite;
    logic        writeOk;
    logic        filterClear;
    logic [3:0]  evOneHot;
    logic        pwmRise;
    logic        capSyncRise;
    logic        xbarSyncRise;
    logic        pwmSyncRise;
    logic [1:0]  stopValue;
    logic        contMode;

    assign contMode  = captureControlTwo[CT_CONT];
    assign stopValue = captureControlTwo[CT_STOPLO +: 2];

    // ----------------------------------------------------------------
    // APB slave: zero wait states, unmapped addresses error
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign wrEn   = psel & penable & pwrite;

    // Input select, sync select, period and compare writes need the unlock unless the legacy select is set
    assign critWrite = (paddr == CTRL0_OFS) || (paddr == SYNCSEL_OFS) ||
                       (paddr == PERIOD_OFS) || (paddr == CMP_OFS);
    assign writeOk   = ~critWrite | unlocked | legacyProtectionSelect;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (paddr[1:0] != 2'b00 || paddr > UNLOCK_OFS) begin
                pslverr = 1'b1;
            end else if (pwrite && !writeOk) begin
                pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            unlocked <= 1'b0;
        end else if (wrEn && paddr == UNLOCK_OFS) begin
            unlocked <= pwdata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            captureInputSelect <= INSEL_RST;
            syncSourceSelect   <= SYNCSEL_RST;
            period             <= PERIOD_RST;
            compare            <= ERR_DATA;
        end else if (wrEn && writeOk) begin
            case (paddr)
                CTRL0_OFS:   captureInputSelect <= pwdata[6:0];
                SYNCSEL_OFS: syncSourceSelect   <= pwdata[1:0];
                PERIOD_OFS:  period             <= pwdata;
                CMP_OFS:     compare            <= pwdata;
                default: ;
            endcase
        end
    end

    // Self-clearing strobes (rearm, software sync, filter clear) read back 0
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            captureControlTwo <= CTRL2_RST;
            intEnable         <= 4'h0;
            phase             <= ERR_DATA;
        end else if (wrEn) begin
            case (paddr)
                CTRL2_OFS: begin
                    captureControlTwo <= pwdata;
                    captureControlTwo[CT_REARM]  <= 1'b0;
                    captureControlTwo[CT_SWSYNC] <= 1'b0;
                    captureControlTwo[CT_CLEAR]  <= 1'b0;
                    captureControlTwo[CT_SEQLO +: 2] <= 2'b00;
                end
                INTEN_OFS: intEnable <= pwdata[3:0];
                PHASE_OFS: phase     <= pwdata;
                default: ;
            endcase
        end
    end

    assign filterClear = wrEn && paddr == CTRL2_OFS && pwdata[CT_CLEAR];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= ERR_DATA;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CTRL0_OFS:   prdata <= {25'h0, captureInputSelect};
                CTRL2_OFS:   prdata <= {captureControlTwo[31:11], seq,
                                        captureControlTwo[8:0]};
                FLAG_OFS:    prdata <= {28'h0, flags};
                INTEN_OFS:   prdata <= {28'h0, intEnable};
                SYNCSEL_OFS: prdata <= {30'h0, syncSourceSelect};
                PHASE_OFS:   prdata <= phase;
                COUNT_OFS:   prdata <= counter;
                8'h20:       prdata <= capReg[0];
                8'h24:       prdata <= capReg[1];
                8'h28:       prdata <= capReg[2];
                8'h2c:       prdata <= capReg[3];
                PERIOD_OFS:  prdata <= period;
                CMP_OFS:     prdata <= compare;
                UNLOCK_OFS:  prdata <= {31'h0, unlocked};
                default:     prdata <= ERR_DATA;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Input selection and edge detection
    // ----------------------------------------------------------------
    // All 128 inputs are synchronised so the mux never sees a raw pin
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inMeta  <= '0;
            inSync  <= '0;
            selLast <= 1'b0;
        end else begin
            inMeta  <= captureInputs;
            inSync  <= inMeta;
            selLast <= selNow;
        end
    end

    assign selNow = inSync[captureInputSelect];
    assign evRise = selNow & ~selLast;
    assign evFall = ~selNow & selLast;
    assign evHit  = captureControlTwo[CT_POL0 + seq] ? evFall : evRise;
    assign capEvent = evHit && armed && captureControlTwo[CT_RUN] &&
                      !captureControlTwo[CT_PWMMODE] && !filterClear;
    assign evOneHot = capEvent ? (4'h1 << seq) : 4'h0;

    // ----------------------------------------------------------------
    // Sync sources
    // ----------------------------------------------------------------
    edge_pick u_pwm_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (pwmSync),
        .rise     (pwmSyncRise),
        .fall     ()
    );
    edge_pick u_cap_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (capSync),
        .rise     (capSyncRise),
        .fall     ()
    );
    edge_pick u_xbar_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (xbarSync),
        .rise     (xbarSyncRise),
        .fall     ()
    );

    always_comb begin
        case (sync_src_t'(syncSourceSelect))
            SYNC_PWM:  extSync = pwmSyncRise;
            SYNC_CAP:  extSync = capSyncRise;
            SYNC_XBAR: extSync = xbarSyncRise;
            default:   extSync = 1'b0;
        endcase
    end

    assign syncEvent = captureControlTwo[CT_SYNCEN] &&
                       (extSync || (wrEn && paddr == CTRL2_OFS && pwdata[CT_SWSYNC]));

    // ----------------------------------------------------------------
    // Time base: sync load, delta reset, PWM period wrap
    // ----------------------------------------------------------------
    assign pwmRise = captureControlTwo[CT_PWMMODE] && counter >= period;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            counter <= ERR_DATA;
        end else if (syncEvent) begin
            counter <= phase;
        end else if (capEvent && captureControlTwo[CT_DELTA0 + seq]) begin
            counter <= 32'h0000_0001;
        end else if (pwmRise) begin
            counter <= ERR_DATA;
        end else if (captureControlTwo[CT_RUN]) begin
            counter <= counter + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Capture sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seq   <= 2'b00;
            armed <= 1'b1;
        end else if (filterClear) begin
            seq   <= 2'b00;
            armed <= 1'b1;
        end else if (wrEn && paddr == CTRL2_OFS && pwdata[CT_REARM]) begin
            seq   <= 2'b00;
            armed <= 1'b1;
        end else if (capEvent) begin
            seq <= seq + 2'b01;
            if (!contMode && seq == stopValue) begin
                armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (capEvent) begin
            capReg[seq] <= counter;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags <= 4'h0;
        end else begin
            flags <= (flags & ~((wrEn && paddr == FLGCLR_OFS) ? pwdata[3:0] : 4'h0)
                     & ~{4{filterClear}}) | evOneHot;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            captureIrq        <= 1'b0;
            captureDmaTrigger <= 1'b0;
        end else begin
            captureIrq        <= |(flags & intEnable);
            captureDmaTrigger <= capEvent &&
                                 seq == captureControlTwo[CT_DMALO +: 2];
        end
    end

    // ----------------------------------------------------------------
    // Auxiliary PWM
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= captureControlTwo[CT_PWMMODE] && counter < compare;
        end
    end
    assign auxPwmOutput = pwmOut;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_irq_follows;
        @(posedge core_clk) disable iff (!rstn)
        |(flags & intEnable) |=> captureIrq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

    property p_flag_set;
        @(posedge core_clk) disable iff (!rstn)
        capEvent |=> flags[$past(seq)];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_seq_adv;
        @(posedge core_clk) disable iff (!rstn)
        (capEvent && !filterClear && !(wrEn && paddr == CTRL2_OFS && pwdata[CT_REARM]))
            |=> seq == $past(seq) + 2'b01;
    endproperty
    a_seq_adv: assert property (p_seq_adv) else $error("seq no advance");

    property p_clear;
        @(posedge core_clk) disable iff (!rstn)
        filterClear |=> seq == 2'b00 && flags == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_capture;
        @(posedge core_clk) disable iff (!rstn)
        capEvent |=> capReg[$past(seq)] == $past(counter);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_oneshot;
        @(posedge core_clk) disable iff (!rstn)
        (capEvent && !contMode && seq == stopValue &&
         !(wrEn && paddr == CTRL2_OFS && pwdata[CT_REARM])) |=> !armed;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("not stopped");

    property p_sync;
        @(posedge core_clk) disable iff (!rstn)
        syncEvent |=> counter == $past(phase);
    endproperty
    a_sync: assert property (p_sync) else $error("sync load wrong");

    property p_lock;
        @(posedge core_clk) disable iff (!rstn)
        (wrEn && paddr == PERIOD_OFS && !unlocked && !legacyProtectionSelect)
            |=> period == $past(period);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write");

    property p_delta;
        @(posedge core_clk) disable iff (!rstn)
        (capEvent && !syncEvent && captureControlTwo[CT_DELTA0 + seq])
            |=> counter == 32'h0000_0001;
    endproperty
    a_delta: assert property (p_delta) else $error("delta reset");

    c_event: cover property (@(posedge core_clk) capEvent);
    c_wrap: cover property (@(posedge core_clk) capEvent && seq == 2'b11 && contMode);
    c_stop: cover property (@(posedge core_clk) armed ##1 !armed);
    c_pwm: cover property (@(posedge core_clk) pwmRise);
endmodule // event_capture_timestamp

/* File: pulse_source.sv */
`timescale 1ns/100ps
module pulse_source (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [6:0]   chan,
    input  wire logic         toggleReq,
    input  wire logic [1:0]   syncReq,
    output logic [127:0]      captureInputs,
    output logic              pwmSync,
    output logic              capSync,
    output logic              xbarSync
);
    logic [31:0] noise;
    logic        level;
    logic [1:0]  syncSrc;
    logic [1:0]  syncLeft;

    // ----------------------------------------------------------------
    // Sensor level and sync pulses
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            noise    <= 32'h0;
            level    <= 1'b0;
            syncSrc  <= 2'h0;
            syncLeft <= 2'h0;
        end else begin
            noise <= noise + 32'h1;
            if (toggleReq) begin
                level <= ~level;
            end
            if (syncReq != 2'h0) begin
                syncSrc  <= syncReq;
                syncLeft <= 2'h2;
            end else if (syncLeft != 2'h0) begin
                syncLeft <= syncLeft - 2'h1;
            end
        end
    end

    // Unselected channels carry a free-running count, so a wrong input select shows up as stray events
    always_comb begin
        captureInputs       = {4{noise}};
        captureInputs[chan] = level;
    end

    // Two-cycle pulses keep the minimum sync width
    assign pwmSync  = (syncLeft != 2'h0) && (syncSrc == 2'h1);
    assign capSync  = (syncLeft != 2'h0) && (syncSrc == 2'h2);
    assign xbarSync = (syncLeft != 2'h0) && (syncSrc == 2'h3);
endmodule // pulse_source

/* File: event_capture_timestamp_tb_top.sv */
`timescale 1ns/100ps
module event_capture_timestamp_tb_top
    import evcap_pkg::*;
;
    localparam int          N      = 20;
    localparam logic [31:0] RUN    = 32'h1 << CT_RUN;
    localparam logic [31:0] CONT   = 32'h1 << CT_CONT;
    localparam logic [31:0] SYNCEN = 32'h1 << CT_SYNCEN;
    logic         core_clk;
    logic         rstn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [127:0] captureInputs;
    logic         pwmSync;
    logic         capSync;
    logic         xbarSync;
    logic         legacy;
    logic         captureIrq;
    logic         captureDmaTrigger;
    logic         auxPwmOutput;
    logic [6:0]   chan;
    logic         toggleReq;
    logic [1:0]   syncReq;
    int           nErrors;
    int           cmpCount;
    int           dmaCount;

    event_capture_timestamp dut_u (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .captureInputs(captureInputs), .pwmSync(pwmSync),
        .capSync(capSync), .xbarSync(xbarSync), .legacyProtectionSelect(legacy),
        .captureIrq(captureIrq), .captureDmaTrigger(captureDmaTrigger),
        .auxPwmOutput(auxPwmOutput));
    pulse_source src_u (.core_clk(core_clk), .rstn(rstn), .chan(chan), .toggleReq(toggleReq),
        .syncReq(syncReq), .captureInputs(captureInputs), .pwmSync(pwmSync),
        .capSync(capSync), .xbarSync(xbarSync));

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (captureDmaTrigger === 1'b1) begin
            dmaCount <= dmaCount + 1;
        end
    end

    // ----------------------------------------------------------------
    // Bus and checking tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdv(input logic [7:0] a, output logic [31:0] v);
        logic e;
        apb(1'b0, a, 32'h0, v, e);
    endtask

    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rdv(a, v);
        chk(nm, v, exp);
    endtask

    // One input toggle, then the rest of an N-cycle spacing
    task automatic toggle();
        @(posedge core_clk);
        toggleReq <= 1'b1;
        @(posedge core_clk);
        toggleReq <= 1'b0;
        repeat (N - 2) @(posedge core_clk);
    endtask

    task automatic syncPulse(input logic [1:0] src);
        @(posedge core_clk);
        syncReq <= src;
        @(posedge core_clk);
        syncReq <= 2'h0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic results();
        $display("counts: %0d compares, %0d mismatches", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        results();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [31:0] c [4];
        logic        e;
        int          d0;
        int          hi;
        core_clk = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        legacy = 1'b0;
        chan = 7'h05;
        toggleReq = 1'b0;
        syncReq = 2'h0;
        nErrors = 0;
        cmpCount = 0;
        dmaCount = 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rdChk("ctrl2", CTRL2_OFS, CTRL2_RST);
        rdChk("period", PERIOD_OFS, PERIOD_RST);
        rdChk("flags", FLAG_OFS, 32'h0);
        $display("test reset done");
        apb(1'b1, CTRL0_OFS, 32'h5, v, e);
        chk("lockedErr", {31'h0, e}, 32'h1);
        rdChk("inselKept", CTRL0_OFS, 32'h0);
        legacy <= 1'b1;
        apb(1'b1, SYNCSEL_OFS, 32'h2, v, e);
        chk("legacyErr", {31'h0, e}, 32'h0);
        rdChk("syncsel", SYNCSEL_OFS, 32'h2);
        legacy <= 1'b0;
        apb(1'b0, 8'h3c, 32'h0, v, e);
        chk("unmappedErr", {31'h0, e}, 32'h1);
        chk("unmappedData", v, ERR_DATA);
        wr(UNLOCK_OFS, 32'h1);
        wr(CTRL0_OFS, 32'h7f);
        rdChk("insel", CTRL0_OFS, 32'h7f);
        chan <= 7'h7f;
        $display("test protection done");
        wr(CTRL2_OFS, RUN | (32'h3 << CT_STOPLO) | (32'ha << CT_POL0));
        repeat (5) toggle();
        for (int i = 0; i < 4; i++) begin
            rdv(CAP0_OFS + 8'(4 * i), c[i]);
        end
        for (int i = 1; i < 4; i++) begin
            chk("capStep", c[i] - c[i - 1], 32'(N));
        end
        rdChk("flagsOneShot", FLAG_OFS, 32'hf);
        wr(CTRL2_OFS, RUN | (32'h3 << CT_STOPLO) | (32'h1 << CT_REARM));
        repeat (2) toggle();
        rdv(CTRL2_OFS, v);
        chk("seqRearm", {30'h0, v[CT_SEQLO +: 2]}, 32'h1);
        $display("test single shot done");
        wr(CTRL2_OFS, RUN | (32'h1 << CT_CLEAR));
        rdChk("flagsCleared", FLAG_OFS, 32'h0);
        rdv(CTRL2_OFS, v);
        chk("seqCleared", {30'h0, v[CT_SEQLO +: 2]}, 32'h0);
        wr(INTEN_OFS, 32'h4);
        wr(CTRL2_OFS, RUN | CONT | (32'hf << CT_DELTA0) | (32'h3 << CT_DMALO));
        d0 = dmaCount;
        repeat (12) toggle();
        for (int i = 0; i < 4; i++) begin
            rdv(CAP0_OFS + 8'(4 * i), v);
            chk("deltaCap", v, 32'(2 * N));
        end
        rdv(CTRL2_OFS, v);
        chk("seqWrap", {30'h0, v[CT_SEQLO +: 2]}, 32'h2);
        chk("dmaPulses", 32'(dmaCount - d0), 32'h1);
        chk("irqSet", {31'h0, captureIrq}, 32'h1);
        wr(FLGCLR_OFS, 32'h4);
        repeat (3) @(posedge core_clk);
        chk("irqClear", {31'h0, captureIrq}, 32'h0);
        rdChk("flagsLeft", FLAG_OFS, 32'hb);
        $display("test continuous delta done");
        wr(CTRL2_OFS, RUN | SYNCEN);
        wr(PHASE_OFS, 32'h8000_0000);
        wr(SYNCSEL_OFS, 32'h1);
        syncPulse(2'h2);
        rdv(COUNT_OFS, v);
        chk("unselectedSync", {31'h0, v[31]}, 32'h0);
        syncPulse(2'h1);
        rdv(COUNT_OFS, v);
        chk("extPhase", {31'h0, (v - 32'h8000_0000) < 32'd40}, 32'h1);
        for (int s = 2; s < 4; s++) begin
            wr(PHASE_OFS, 32'(s) << 28);
            wr(SYNCSEL_OFS, 32'(s));
            syncPulse(2'(s));
            rdv(COUNT_OFS, v);
            chk("extPhaseSrc", {31'h0, (v - (32'(s) << 28)) < 32'd40}, 32'h1);
        end
        wr(PHASE_OFS, 32'h4000_0000);
        wr(SYNCSEL_OFS, 32'h0);
        wr(CTRL2_OFS, RUN | SYNCEN | (32'h1 << CT_SWSYNC));
        rdv(COUNT_OFS, v);
        chk("swPhase", {31'h0, (v - 32'h4000_0000) < 32'd40}, 32'h1);
        $display("test sync done");
        wr(PERIOD_OFS, 32'h9);
        wr(CMP_OFS, 32'h3);
        wr(CTRL2_OFS, RUN | (32'h1 << CT_PWMMODE));
        repeat (20) @(posedge core_clk);
        hi = 0;
        repeat (20) begin
            @(negedge core_clk);
            hi += int'(auxPwmOutput === 1'b1);
        end
        chk("pwmHigh", 32'(hi), 32'h6);
        $display("test pwm done");
        results();
    end
endmodule // event_capture_timestamp_tb_top
